/* File: core/trsm_consts.vh */
`ifndef TRSM_CONSTS_VH
`define TRSM_CONSTS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TRSM_A_COOL_ON 8'h00
`define TRSM_A_COOL_OFF 8'h04
`define TRSM_A_HEAT_ON 8'h08
`define TRSM_A_HEAT_OFF 8'h0c
`define TRSM_A_OVERRUN 8'h10
`define TRSM_A_CANOPY_ON 8'h14
`define TRSM_A_CANOPY_OFF 8'h18
`define TRSM_A_AMB_ON 8'h1c
`define TRSM_A_AMB_OFF 8'h20
`define TRSM_A_EMU_CTRL 8'h24
`define TRSM_A_SVC_CTRL 8'h28
`define TRSM_A_RELAY_STAT 8'h2c
`define TRSM_A_INT_STAT 8'h30
`define TRSM_A_INT_MASK 8'h34
`define TRSM_A_SVC0_HOURS 8'h40
`define TRSM_A_SVC0_MONTHS 8'h44
`define TRSM_A_SVC0_LEVEL 8'h48
`define TRSM_A_SVC0_ACC 8'h4c
`define TRSM_SVC_STRIDE 8'h10
// ----------------------------------------
// reset values
// ----------------------------------------
`define TRSM_RST_COOL_ON 8'h5a
`define TRSM_RST_COOL_OFF 8'h50
`define TRSM_RST_HEAT_ON 8'h32
`define TRSM_RST_HEAT_OFF 8'h3c
`define TRSM_RST_OVERRUN 8'h00
`define TRSM_RST_FAN_ON 8'h5a
`define TRSM_RST_FAN_OFF 8'h50
`define TRSM_RST_SVC_HOURS 13'h00fa
`define TRSM_RST_SVC_MONTHS 5'h06
`define TRSM_RST_SVC0_LEVEL 2'h3
`define TRSM_RST_SVCN_LEVEL 2'h0
// ----------------------------------------
// field layout and timing
// ----------------------------------------
`define TRSM_EMU_EN_BIT 0
`define TRSM_BRAND_LSB 4
`define TRSM_CLK_HZ 250000000
`define TRSM_SEC_CYCLES 28'd250000000
`define TRSM_INT_W 5
`endif

/* File: core/trsm_monitor.v */
// Summary of operation
// - cooler turns on when coolant temperature is above cooler-on.
// - cooler begins release when coolant falls below cooler-off.
// - heater turns on when coolant is below heater-on.
// - heater turns off when coolant is above heater-off.
// - cooler stays on for the overrun seconds after falling below off.
// - canopy fan switches on above and off below its thresholds.
// - ambient fan switches on above and off below its thresholds.
// - a channel requests service when hours reach a nonzero limit.
// - a channel requests service when months reach a nonzero period.
// - there are three independent service channels.
// - a two-bit alarm level sets the reaction of a due channel.
// - with management disabled the engine serial port stays off.
// - with management enabled engine values come from the unit.
// - with management enabled lost communication stops the engine.
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`include "trsm_consts.vh"
`default_nettype none
module trsm_monitor (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [7:0] coolant_temp_i,
    input wire [7:0] canopy_temp_i,
    input wire [7:0] ambient_temp_i,
    input wire [7:0] local_oil_i,
    input wire [7:0] local_temp_i,
    input wire [15:0] local_rpm_i,
    input wire [7:0] emu_oil_i,
    input wire [7:0] emu_temp_i,
    input wire [15:0] emu_rpm_i,
    input wire emu_link_ok_i,
    input wire hour_tick_i,
    input wire month_tick_i,
    input wire [2:0] service_done_i,
    output reg cooler_o,
    output reg heater_o,
    output reg canopy_fan_o,
    output reg ambient_fan_o,
    output reg service_request_o,
    output reg [5:0] service_level_o,
    output reg emu_port_en_o,
    output reg [3:0] emu_brand_o,
    output reg [7:0] oil_o,
    output reg [7:0] temp_o,
    output reg [15:0] rpm_o,
    output reg engine_stop_o,
    output reg irq_o
);
// ----------------------------------------
// helpers
// ----------------------------------------
    // hysteresis: on above hi, off below lo, hold otherwise
    function hyst;
        input cur;
        input [7:0] t;
        input [7:0] hi;
        input [7:0] lo;
        begin
            if (t > hi)
                hyst = 1'b1;
            else if (t < lo)
                hyst = 1'b0;
            else
                hyst = cur;
        end
    endfunction

    function [31:0] wmask;
        input [31:0] old;
        input [31:0] d;
        input [3:0] sel;
        integer k;
        begin
            wmask = old;
            for (k = 0; k < 4; k = k + 1)
                if (sel[k])
                    wmask[k*8 +: 8] = d[k*8 +: 8];
        end
    endfunction

// ----------------------------------------
// input synchronisers
// ----------------------------------------
    reg [7:0] cool_s1, cool_s2, can_s1, can_s2, amb_s1, amb_s2;
    reg [7:0] loil_s1, loil_s2, ltmp_s1, ltmp_s2, eoil_s1, eoil_s2;
    reg [7:0] etmp_s1, etmp_s2;
    reg [15:0] lrpm_s1, lrpm_s2, erpm_s1, erpm_s2;
    reg [5:0] ev_s1, ev_s2, ev_d;
    always @(posedge mclk_i) begin
        cool_s1 <= coolant_temp_i;
        cool_s2 <= cool_s1;
        can_s1 <= canopy_temp_i;
        can_s2 <= can_s1;
        amb_s1 <= ambient_temp_i;
        amb_s2 <= amb_s1;
        loil_s1 <= local_oil_i;
        loil_s2 <= loil_s1;
        ltmp_s1 <= local_temp_i;
        ltmp_s2 <= ltmp_s1;
        lrpm_s1 <= local_rpm_i;
        lrpm_s2 <= lrpm_s1;
        eoil_s1 <= emu_oil_i;
        eoil_s2 <= eoil_s1;
        etmp_s1 <= emu_temp_i;
        etmp_s2 <= etmp_s1;
        erpm_s1 <= emu_rpm_i;
        erpm_s2 <= erpm_s1;
        ev_s1 <= {service_done_i, emu_link_ok_i, month_tick_i,
                  hour_tick_i};
        ev_s2 <= ev_s1;
    end
    always @(posedge mclk_i) begin
        if (sys_rst_i)
            ev_d <= 6'h04; // idle levels: link up, ticks and done low
        else
            ev_d <= ev_s2;
    end
    wire hour_ev = ev_s2[0] & ~ev_d[0];
    wire month_ev = ev_s2[1] & ~ev_d[1];
    wire link_ok = ev_s2[2];
    wire [2:0] done_ev = ev_s2[5:3] & ~ev_d[5:3];

// ----------------------------------------
// configuration registers
// ----------------------------------------
    reg [7:0] cool_on, cool_off, heat_on, heat_off, overrun;
    reg [7:0] can_on, can_off, amb_on, amb_off;
    reg emu_en;
    reg [3:0] brand;
    reg [12:0] svc_hours [0:2];
    reg [4:0] svc_months [0:2];
    reg [1:0] svc_level [0:2];
    reg [12:0] acc_hours [0:2];
    reg [4:0] acc_months [0:2];
    reg [2:0] due;
    reg [`TRSM_INT_W-1:0] int_stat, int_mask;

    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = wb_req & wb_we_i;
    wire [1:0] ch_idx = wb_adr_i[5:4];
    wire ch_hit = (wb_adr_i[7:6] == 2'h1) && (wb_adr_i[5:4] != 2'h3);
    wire [31:0] ch_wr0 = wmask(32'h0, wb_dat_i, wb_sel_i);
    wire [31:0] cur_wr = wmask({24'h0, cool_on}, wb_dat_i, wb_sel_i);

// ----------------------------------------
// cooler overrun timer state and configuration register writes
// ----------------------------------------
    reg cool_dem;
    reg [27:0] sec_cnt;
    reg [7:0] ovr_left;
    wire sec_ev = (sec_cnt == `TRSM_SEC_CYCLES - 28'd1);
    reg [`TRSM_INT_W-1:0] ev_now;
    integer i;

    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cool_on <= `TRSM_RST_COOL_ON;
            cool_off <= `TRSM_RST_COOL_OFF;
            heat_on <= `TRSM_RST_HEAT_ON;
            heat_off <= `TRSM_RST_HEAT_OFF;
            overrun <= `TRSM_RST_OVERRUN;
            can_on <= `TRSM_RST_FAN_ON;
            can_off <= `TRSM_RST_FAN_OFF;
            amb_on <= `TRSM_RST_FAN_ON;
            amb_off <= `TRSM_RST_FAN_OFF;
            emu_en <= 1'b0;
            brand <= 4'h0;
            for (i = 0; i < 3; i = i + 1) begin
                svc_hours[i] <= `TRSM_RST_SVC_HOURS;
                svc_months[i] <= `TRSM_RST_SVC_MONTHS;
                svc_level[i] <= (i == 0) ? `TRSM_RST_SVC0_LEVEL :
                                `TRSM_RST_SVCN_LEVEL;
            end
            int_mask <= {`TRSM_INT_W{1'b0}};
        end else if (wr) begin
            case (wb_adr_i)
            `TRSM_A_COOL_ON: cool_on <= cur_wr[7:0];
            `TRSM_A_COOL_OFF: cool_off <= ch_wr0[7:0];
            `TRSM_A_HEAT_ON: heat_on <= ch_wr0[7:0];
            `TRSM_A_HEAT_OFF: heat_off <= ch_wr0[7:0];
            `TRSM_A_OVERRUN: overrun <= ch_wr0[7:0];
            `TRSM_A_CANOPY_ON: can_on <= ch_wr0[7:0];
            `TRSM_A_CANOPY_OFF: can_off <= ch_wr0[7:0];
            `TRSM_A_AMB_ON: amb_on <= ch_wr0[7:0];
            `TRSM_A_AMB_OFF: amb_off <= ch_wr0[7:0];
            `TRSM_A_EMU_CTRL: begin
                emu_en <= ch_wr0[`TRSM_EMU_EN_BIT];
                brand <= ch_wr0[`TRSM_BRAND_LSB +: 4];
            end
            `TRSM_A_INT_MASK: int_mask <= ch_wr0[`TRSM_INT_W-1:0];
            default: begin
                if (ch_hit)
                    case (wb_adr_i[3:0])
                    4'h0: svc_hours[ch_idx] <= ch_wr0[12:0];
                    4'h4: svc_months[ch_idx] <= ch_wr0[4:0];
                    4'h8: svc_level[ch_idx] <= ch_wr0[1:0];
                    default: ;
                    endcase
            end
            endcase
        end
    end

// ----------------------------------------
// relays and overrun
// ----------------------------------------
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cool_dem <= 1'b0;
            cooler_o <= 1'b0;
            heater_o <= 1'b0;
            canopy_fan_o <= 1'b0;
            ambient_fan_o <= 1'b0;
            sec_cnt <= 28'd0;
            ovr_left <= 8'h00;
        end else begin
            cool_dem <= hyst(cool_dem, cool_s2, cool_on, cool_off);
            sec_cnt <= sec_ev ? 28'd0 : sec_cnt + 28'd1;
            if (cool_dem && cool_s2 < cool_off) begin
                ovr_left <= overrun;
                sec_cnt <= 28'd0;
            end else if (sec_ev && ovr_left != 8'h00)
                ovr_left <= ovr_left - 8'h01;
            // stays on while demand or overrun seconds remain
            cooler_o <= hyst(cool_dem, cool_s2, cool_on, cool_off) |
                        (cool_dem & (cool_s2 < cool_off) &
                         (overrun != 8'h00)) |
                        (ovr_left != 8'h00);
            heater_o <= hyst(heater_o, heat_off, heat_off, 8'h00) ?
                        (cool_s2 > heat_off ? 1'b0 : heater_o) :
                        (cool_s2 < heat_on ? 1'b1 : heater_o);
            canopy_fan_o <= hyst(canopy_fan_o, can_s2, can_on,
                                 can_off);
            ambient_fan_o <= hyst(ambient_fan_o, amb_s2, amb_on,
                                  amb_off);
        end
    end

// ----------------------------------------
// service channels
// ----------------------------------------
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            for (i = 0; i < 3; i = i + 1) begin
                acc_hours[i] <= 13'h0000;
                acc_months[i] <= 5'h00;
            end
            due <= 3'h0;
            service_request_o <= 1'b0;
            service_level_o <= 6'h00;
        end else begin
            for (i = 0; i < 3; i = i + 1) begin
                if (done_ev[i]) begin
                    acc_hours[i] <= 13'h0000;
                    acc_months[i] <= 5'h00;
                    due[i] <= 1'b0;
                end else begin
                    if (hour_ev && acc_hours[i] != 13'h1fff)
                        acc_hours[i] <= acc_hours[i] + 13'h0001;
                    if (month_ev && acc_months[i] != 5'h1f)
                        acc_months[i] <= acc_months[i] + 5'h01;
                    if ((svc_hours[i] != 13'h0000 &&
                         acc_hours[i] >= svc_hours[i]) ||
                        (svc_months[i] != 5'h00 &&
                         acc_months[i] >= svc_months[i]))
                        due[i] <= 1'b1;
                end
                service_level_o[i*2 +: 2] <= due[i] ? svc_level[i] :
                                             2'h0;
            end
            service_request_o <= |due;
        end
    end

// ----------------------------------------
// engine management path
// ----------------------------------------
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            emu_port_en_o <= 1'b0;
            emu_brand_o <= 4'h0;
            oil_o <= 8'h00;
            temp_o <= 8'h00;
            rpm_o <= 16'h0000;
            engine_stop_o <= 1'b0;
        end else begin
            emu_port_en_o <= emu_en;
            emu_brand_o <= brand;
            oil_o <= emu_en ? eoil_s2 : loil_s2;
            temp_o <= emu_en ? etmp_s2 : ltmp_s2;
            rpm_o <= emu_en ? erpm_s2 : lrpm_s2;
            engine_stop_o <= emu_en & ~link_ok;
        end
    end

// ----------------------------------------
// interrupts and bus answer
// ----------------------------------------
    always @* begin
        ev_now = {emu_en & ~link_ok & ev_d[2], // link lost edge
                  cooler_o & ~cool_dem & (ovr_left == 8'h01) & sec_ev,
                  due != 3'h0 & ~service_request_o,
                  cool_dem ^ hyst(cool_dem, cool_s2, cool_on, cool_off),
                  1'b0};
        ev_now[0] = canopy_fan_o ^ hyst(canopy_fan_o, can_s2, can_on,
                                        can_off);
    end

    reg [31:0] rd;
    always @* begin
        rd = 32'h0;
        case (wb_adr_i)
        `TRSM_A_COOL_ON: rd = {24'h0, cool_on};
        `TRSM_A_COOL_OFF: rd = {24'h0, cool_off};
        `TRSM_A_HEAT_ON: rd = {24'h0, heat_on};
        `TRSM_A_HEAT_OFF: rd = {24'h0, heat_off};
        `TRSM_A_OVERRUN: rd = {24'h0, overrun};
        `TRSM_A_CANOPY_ON: rd = {24'h0, can_on};
        `TRSM_A_CANOPY_OFF: rd = {24'h0, can_off};
        `TRSM_A_AMB_ON: rd = {24'h0, amb_on};
        `TRSM_A_AMB_OFF: rd = {24'h0, amb_off};
        `TRSM_A_EMU_CTRL: rd = {24'h0, brand, 3'h0, emu_en};
        `TRSM_A_SVC_CTRL: rd = {29'h0, due};
        `TRSM_A_RELAY_STAT: rd = {24'h0, ovr_left != 8'h00, engine_stop_o,
                                  emu_port_en_o, service_request_o,
                                  ambient_fan_o, canopy_fan_o, heater_o,
                                  cooler_o};
        `TRSM_A_INT_STAT: rd = {27'h0, int_stat};
        `TRSM_A_INT_MASK: rd = {27'h0, int_mask};
        default: begin
            if (ch_hit)
                case (wb_adr_i[3:0])
                4'h0: rd = {19'h0, svc_hours[ch_idx]};
                4'h4: rd = {27'h0, svc_months[ch_idx]};
                4'h8: rd = {30'h0, svc_level[ch_idx]};
                default: rd = {11'h0, acc_months[ch_idx], 3'h0,
                               acc_hours[ch_idx]};
                endcase
        end
        endcase
    end

    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            int_stat <= {`TRSM_INT_W{1'b0}};
            irq_o <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            // a new event wins over a write-one clear
            if (wr && wb_adr_i == `TRSM_A_INT_STAT)
                int_stat <= (int_stat & ~ch_wr0[`TRSM_INT_W-1:0]) | ev_now;
            else
                int_stat <= int_stat | ev_now;
            irq_o <= |(int_stat & int_mask);
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd : 32'h0;
        end
    end
endmodule // trsm_monitor
`default_nettype wire

/* File: dv/trsm_emu_model.sv */
`default_nettype none
module trsm_emu_model (
    input wire logic mclk_i,
    input wire logic port_en_i,
    input wire logic link_up_i,
    output logic [7:0] emu_oil_o,
    output logic [7:0] emu_temp_o,
    output logic [15:0] emu_rpm_o,
    output logic link_ok_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] noise = 8'h00;
    always @(posedge mclk_i) begin
        noise <= noise + 8'h35;
    end
    // ----------------------------------------
    // readings
    // ----------------------------------------
    // a closed port shows a moving pattern so stale data never looks valid
    assign emu_oil_o = port_en_i ? 8'h40 + {5'h00, noise[2:0]} : noise;
    assign emu_temp_o = port_en_i ? 8'h58 : ~noise;
    assign emu_rpm_o = port_en_i ? 16'h05d0 + {13'h0, noise[2:0]}
                                 : {noise, ~noise};
    assign link_ok_o = link_up_i;
endmodule // trsm_emu_model
`default_nettype wire

/* File: dv/trsm_monitor_assertions.sv */
`default_nettype none
module trsm_monitor_assertions (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic emu_port_en_o,
    input wire logic emu_link_ok_i,
    input wire logic engine_stop_o,
    input wire logic [7:0] oil_o,
    input wire logic [7:0] emu_oil_i,
    input wire logic [7:0] local_oil_i,
    input wire logic [15:0] rpm_o,
    input wire logic [15:0] emu_rpm_i,
    input wire logic [15:0] local_rpm_i,
    input wire logic [2:0] service_done_i,
    input wire logic service_request_o,
    input wire logic [5:0] service_level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_link_lost;
        (emu_port_en_o && !emu_link_ok_i)[*4];
    endsequence
    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_ack_next: assert property (s_req |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |->
        $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    a_link_stop: assert property (s_link_lost |-> ##[0:2] engine_stop_o)
        else $error("engine not stopped on link loss");
    a_stop_cause: assert property (engine_stop_o |->
        emu_port_en_o || $past(emu_port_en_o))
        else $error("stop while port disabled");
    // two synchroniser stages plus the output register
    a_emu_path: assert property (!$past(sys_rst_i) && emu_port_en_o &&
        $past(emu_port_en_o) |-> oil_o == $past(emu_oil_i, 3) &&
        rpm_o == $past(emu_rpm_i, 3))
        else $error("engine values not from unit");
    a_local_path: assert property (!$past(sys_rst_i) && !emu_port_en_o &&
        !$past(emu_port_en_o) |-> oil_o == $past(local_oil_i, 3) &&
        rpm_o == $past(local_rpm_i, 3))
        else $error("engine values not local");
    a_done_clears: assert property ($rose(service_done_i[0]) |->
        ##[1:5] service_level_o[1:0] == 2'h0)
        else $error("service done did not clear channel");
    a_level_req: assert property (|service_level_o |-> service_request_o)
        else $error("level without request");
endmodule // trsm_monitor_assertions
bind trsm_monitor trsm_monitor_assertions i_sva (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .emu_port_en_o(emu_port_en_o),
    .emu_link_ok_i(emu_link_ok_i), .engine_stop_o(engine_stop_o),
    .oil_o(oil_o), .emu_oil_i(emu_oil_i), .local_oil_i(local_oil_i),
    .rpm_o(rpm_o), .emu_rpm_i(emu_rpm_i), .local_rpm_i(local_rpm_i),
    .service_done_i(service_done_i), .service_request_o(service_request_o),
    .service_level_o(service_level_o)
);
`default_nettype wire

/* File: dv/testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, link_up = 1'b1, hour_tick_i = 1'b0, month_tick_i = 1'b0;
    logic [7:0] coolant_temp_i = 8'h46, canopy_temp_i = 8'h46;
    logic [7:0] ambient_temp_i = 8'h46, emu_oil_i, emu_temp_i, oil_o, temp_o;
    logic [15:0] emu_rpm_i, rpm_o;
    logic [2:0] service_done_i = 3'h0;
    logic [5:0] service_level_o;
    logic [3:0] emu_brand_o;
    logic emu_link_ok_i, cooler_o, heater_o, canopy_fan_o, ambient_fan_o;
    logic service_request_o, emu_port_en_o, engine_stop_o, irq_o;
    int n_fail = 0, checks_done = 0;
    // coolant, canopy, ambient, then cooler heater canopy ambient relays
    logic [27:0] rows [0:8] = '{28'h464646_0, 28'h285555_4, 28'h375b5b_7,
        28'h5b5555_b, 28'h554f55_9, 28'h5a505a_9, 28'h4f5a4f_0,
        28'h325151_0, 28'h315151_4};
    logic [15:0] defs [0:15] = '{16'h005a, 16'h0450, 16'h0832, 16'h0c3c,
        16'h1000, 16'h145a, 16'h1850, 16'h1c5a, 16'h2050, 16'h2400,
        16'h40fa, 16'h4406, 16'h4803, 16'h5800, 16'h6800, 16'hfc00};
    logic [15:0] cfg [0:9] = '{16'h3400, 16'h301f, 16'h4003, 16'h4400,
        16'h4803, 16'h5000, 16'h5402, 16'h5801, 16'h6003, 16'h6802};
    always #2 mclk_i = ~mclk_i;
    trsm_monitor i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .coolant_temp_i(coolant_temp_i), .canopy_temp_i(canopy_temp_i),
        .ambient_temp_i(ambient_temp_i), .local_oil_i(8'h11),
        .local_temp_i(8'h22), .local_rpm_i(16'h0333), .emu_oil_i(emu_oil_i),
        .emu_temp_i(emu_temp_i), .emu_rpm_i(emu_rpm_i),
        .emu_link_ok_i(emu_link_ok_i), .hour_tick_i(hour_tick_i),
        .month_tick_i(month_tick_i), .service_done_i(service_done_i),
        .cooler_o(cooler_o), .heater_o(heater_o), .canopy_fan_o(canopy_fan_o),
        .ambient_fan_o(ambient_fan_o), .service_request_o(service_request_o),
        .service_level_o(service_level_o), .emu_port_en_o(emu_port_en_o),
        .emu_brand_o(emu_brand_o), .oil_o(oil_o), .temp_o(temp_o),
        .rpm_o(rpm_o), .engine_stop_o(engine_stop_o), .irq_o(irq_o));
    trsm_emu_model i_emu (.mclk_i(mclk_i), .port_en_i(emu_port_en_o),
        .link_up_i(link_up), .emu_oil_o(emu_oil_i), .emu_temp_o(emu_temp_i),
        .emu_rpm_o(emu_rpm_i), .link_ok_o(emu_link_ok_i));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // the slave's answer time is not assumed, only bounded
        for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge mclk_i);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            chk("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(what, exp, q);
    endtask
    task automatic pulse(input logic month);
        @(posedge mclk_i);
        hour_tick_i <= !month;
        month_tick_i <= month;
        idle(3);
        hour_tick_i <= 1'b0;
        month_tick_i <= 1'b0;
        idle(3);
    endtask
    task automatic do_reset();
        sys_rst_i <= 1'b1;
        idle(4);
        sys_rst_i <= 1'b0;
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        do_reset();
        foreach (rows[i]) begin
            @(posedge mclk_i);
            coolant_temp_i <= rows[i][27:20];
            canopy_temp_i <= rows[i][19:12];
            ambient_temp_i <= rows[i][11:4];
            idle(6);
            chk("relays", {28'h0, rows[i][3:0]}, {28'h0, cooler_o, heater_o,
                canopy_fan_o, ambient_fan_o});
        end
        foreach (defs[i])
            rd("reset value", defs[i][15:8], {24'h0, defs[i][7:0]});
        wr(8'hfc, 32'hffff_ffff);
        wr(8'h28, 32'hffff_ffff);
        rd("unmapped", 8'hfc, 32'h0);
        rd("due flags", 8'h28, 32'h0);
        // the second is not shortened, so only the start of overrun is seen
        wr(8'h10, 32'h1);
        @(posedge mclk_i);
        coolant_temp_i <= 8'h64;
        idle(6);
        @(posedge mclk_i);
        coolant_temp_i <= 8'h46;
        idle(40);
        chk("cooler_o", 32'h1, {31'h0, cooler_o});
        rd("relay status", 8'h2c, 32'h81);
        do_reset();
        idle(1);
        chk("cooler_o", 32'h0, {31'h0, cooler_o});
        rd("overrun", 8'h10, 32'h0);
        foreach (cfg[i])
            wr(cfg[i][15:8], {24'h0, cfg[i][7:0]});
        pulse(1'b0);
        pulse(1'b0);
        chk("service_request_o", 32'h0, {31'h0, service_request_o});
        pulse(1'b0);
        chk("service_level_o", 32'h23, {26'h0, service_level_o});
        chk("service_request_o", 32'h1, {31'h0, service_request_o});
        pulse(1'b1);
        chk("service_level_o", 32'h23, {26'h0, service_level_o});
        pulse(1'b1);
        chk("service_level_o", 32'h27, {26'h0, service_level_o});
        rd("due flags", 8'h28, 32'h7);
        rd("int status", 8'h30, 32'h4);
        chk("irq_o", 32'h0, {31'h0, irq_o});
        // the due event stays masked here, so the line must stay low
        wr(8'h34, 32'h1b);
        idle(2);
        chk("irq_o", 32'h0, {31'h0, irq_o});
        wr(8'h34, 32'h1f);
        idle(2);
        chk("irq_o", 32'h1, {31'h0, irq_o});
        wr(8'h30, 32'h4);
        idle(2);
        chk("irq_o", 32'h0, {31'h0, irq_o});
        @(posedge mclk_i);
        service_done_i <= 3'h1;
        idle(3);
        service_done_i <= 3'h0;
        idle(4);
        rd("due flags", 8'h28, 32'h6);
        rd("ch0 counters", 8'h4c, 32'h0);
        chk("service_level_o", 32'h24, {26'h0, service_level_o});
        wr(8'h24, 32'he1);
        // unit data must pass the synchronisers after the port opens
        idle(4);
        chk("port and brand", 32'h1e, {27'h0, emu_port_en_o, emu_brand_o});
        chk("oil_o", 32'h8, {27'h0, oil_o[7:3]});
        chk("temp_o", 32'h58, {24'h0, temp_o});
        chk("rpm_o", 32'hba, {19'h0, rpm_o[15:3]});
        chk("engine_stop_o", 32'h0, {31'h0, engine_stop_o});
        @(posedge mclk_i);
        link_up <= 1'b0;
        idle(8);
        chk("engine_stop_o", 32'h1, {31'h0, engine_stop_o});
        rd("int status", 8'h30, 32'h10);
        chk("irq_o", 32'h1, {31'h0, irq_o});
        wr(8'h24, 32'h0);
        idle(2);
        chk("port and stop", 32'h0, {30'h0, emu_port_en_o, engine_stop_o});
        chk("oil and temp", 32'h1122, {16'h0, oil_o, temp_o});
        summarize();
    end
endmodule // testbench
`default_nettype wire
